// [design/iol_pkg.sv]
/*
  Package for the I/O load/store access checker: register offsets,
  status field layout, error codes, target and mapping encodings and
  the state record of the checker.
  Assumes processor-style bit numbering in the status word: bit 0 is
  the most significant bit, so status bits 0 to 3 sit at [31:28].
*/
package iol_pkg;

  // ----------------------------------------------------------------
  // register map (byte offsets on the register port)
  // ----------------------------------------------------------------
  localparam logic [3:0] IOL_OFS_CHANNEL15_STATUS_REG  = 4'h0;
  localparam logic [3:0] IOL_OFS_LIM_LO = 4'h4;
  localparam logic [3:0] IOL_OFS_LIM_HI = 4'h8;

  localparam logic [31:0] IOL_CSR_RST    = 32'h0000_0000;
  localparam logic [31:0] IOL_LIM_LO_RST = 32'h0000_0000;
  localparam logic [31:0] IOL_LIM_HI_RST = 32'h0000_0000;
  localparam logic [31:0] IOL_ZERO32     = 32'h0000_0000;

  // ----------------------------------------------------------------
  // channel15_status_reg layout
  // ----------------------------------------------------------------
  localparam int IOL_CODE_LSB = 28;
  localparam int IOL_MASK_LSB = 16;

  // ----------------------------------------------------------------
  // error codes
  // ----------------------------------------------------------------
  localparam logic [3:0] IOL_ERR_NONE     = 4'h0;
  localparam logic [3:0] IOL_ERR_INV_OP   = 4'h1;
  localparam logic [3:0] IOL_ERR_LIMIT    = 4'h3;
  localparam logic [3:0] IOL_ERR_AUTH     = 4'h5;
  localparam logic [3:0] IOL_ERR_PAGE     = 4'h6;
  localparam logic [3:0] IOL_ERR_CHAN_CHK = 4'h8;
  localparam logic [3:0] IOL_ERR_PARITY   = 4'h9;
  localparam logic [3:0] IOL_ERR_BUS      = 4'hA;
  localparam logic [3:0] IOL_ERR_CSF      = 4'hB;
  localparam logic [3:0] IOL_ERR_ECC      = 4'hC;
  localparam logic [3:0] IOL_ERR_SYS_ADDR = 4'hD;
  localparam logic [3:0] IOL_ERR_RELOAD   = 4'hE;
  localparam logic [3:0] IOL_ERR_INTERNAL = 4'hF;

  // ----------------------------------------------------------------
  // access targets and translation_control_word mapping bits 30..31
  // ----------------------------------------------------------------
  localparam logic [1:0] IOL_TGT_BUS_IO   = 2'h0;
  localparam logic [1:0] IOL_TGT_BUS_MEM  = 2'h1;
  localparam logic [1:0] IOL_TGT_FACILITY = 2'h2;
  localparam logic [1:0] IOL_TGT_UNAUTH   = 2'h3;

  localparam logic [1:0] IOL_MAP_PAGE_FLT = 2'h1;

  typedef struct packed {
    logic [31:0] lim_lo;
    logic [31:0] lim_hi;
    logic [31:0] csr;
    logic [31:0] rd_data;
    logic        chk_done;
    logic        chk_pass;
    logic        dsi;
    logic        misc_int;
    logic        chan_en;
    logic        cc_s1;
    logic        cc_s2;
    logic        cc_s3;
  } iol_state_type;

endpackage

// [design/iol_access_check.sv]
/*
  io_load_store_access_check: authority checking and first-error
  capture for processor I/O load/store on channel 15 of the
  io_channel_controller.
  Assumes access and transfer-response strobes come from logic on
  sys_clk_i; only the asynchronous channel check comes from a pin.
*/
// The strobed register port and the placing of the registers were chosen for this implementation.
// Overview of operation
// - range-check bus I/O; key-check bus memory; write-check system memory
// - bus and system memory load/store run as channel 15 bus master
// - supervisor-loaded low/high limits give one byte-granular I/O range
// - out-of-range bus I/O posts data storage interrupt, limit code
// - no range check when privileged key is 0 or time delay command
// - increment off checks start only; on checks every byte
// - 3-bit page key picks one of 8 mask bits in status register
// - no key check when privileged key is 0 or bypass is 1
// - table, limit and mask facilities need privileged key 0
// - error code latched only when no earlier error is held
// - errors are synchronous; async channel check goes to misc interrupt
// - unauthorized facility or missing table entry gives invalid operation
// - unauthorized key or write to read-only page gives authority error
// - mapping bits 01 give page fault code
// - channel check code; card-select feedback error outranks it
// - parity on load data or entry load; channel check outranks it
// - detected I/O bus error gives bus error code
// - missing card-select feedback with address check on gives its code
// - system bus uncorrectable ECC and missing address acknowledge codes
// - reload error with bypass off; internal table/flush error code
// - channel 15 stays enabled after any error
// - status load returns stored bits 0 to 31
`timescale 1ns/1ps
module iol_access_check
  import iol_pkg::*;
(
  // clock and reset
  input  wire logic        sys_clk_i,
  input  wire logic        reset_n_i,
  // register port
  input  wire logic [3:0]  reg_addr_i,
  input  wire logic [31:0] reg_wdata_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  input  wire logic        reg_priv_key_i,
  output logic      [31:0] reg_rdata_o,
  // access request with segment controls and table entry
  input  wire logic        acc_valid_i,
  input  wire logic [1:0]  acc_target_i,
  input  wire logic [31:0] acc_addr_i,
  input  wire logic [6:0]  acc_len_m1_i,
  input  wire logic        acc_write_i,
  input  wire logic        acc_time_delay_i,
  input  wire logic        seg_priv_key_i,
  input  wire logic        seg_bypass_i,
  input  wire logic        seg_addr_inc_i,
  input  wire logic        tcw_present_i,
  input  wire logic [2:0]  tcw_key_i,
  input  wire logic [1:0]  tcw_map_i,
  input  wire logic        tcw_read_only_i,
  // transfer completion and responses
  input  wire logic        xfer_done_i,
  input  wire logic        xfer_load_i,
  input  wire logic        xfer_addr_chk_i,
  input  wire logic        xfer_bypass_i,
  input  wire logic        card_select_feedback_i,
  input  wire logic        rsp_chan_chk_i,
  input  wire logic        rsp_parity_i,
  input  wire logic        rsp_tcw_par_i,
  input  wire logic        rsp_bus_err_i,
  input  wire logic        rsp_ecc_i,
  input  wire logic        rsp_no_ack_i,
  input  wire logic        rsp_reload_err_i,
  input  wire logic        rsp_internal_i,
  // asynchronous channel check pin
  input  wire logic        chan_chk_async_i,
  // results
  output logic             chk_done_o,
  output logic             chk_pass_o,
  output logic             dsi_o,
  output logic             misc_int_o,
  output logic             chan15_en_o
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic in_range(input logic [31:0] a,
                                    input logic [31:0] lo,
                                    input logic [31:0] hi);
    in_range = (a >= lo) && (a <= hi);
  endfunction

  iol_state_type s;
  iol_state_type n;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [32:0] end_addr;
    logic        range_ok;
    logic [3:0]  acc_code;
    logic [3:0]  xfer_code;
    logic [3:0]  reg_code;
    logic [3:0]  new_code;
    logic [7:0]  mask;
    logic        prot_reg;
    logic        priv_bad;
    end_addr  = 33'h0_0000_0000;
    range_ok  = 1'b1;
    acc_code  = IOL_ERR_NONE;
    xfer_code = IOL_ERR_NONE;
    reg_code  = IOL_ERR_NONE;
    new_code  = IOL_ERR_NONE;
    mask      = s.csr[IOL_MASK_LSB +: 8];
    prot_reg  = 1'b0;
    priv_bad  = 1'b0;

    n          = s;
    n.chk_done = 1'b0;
    n.chk_pass = 1'b0;
    n.dsi      = 1'b0;
    n.rd_data  = IOL_ZERO32;
    n.chan_en  = 1'b1;

    // async check is only ever routed out, never recorded
    n.cc_s1    = chan_chk_async_i;
    n.cc_s2    = s.cc_s1;
    n.cc_s3    = s.cc_s2;
    n.misc_int = s.cc_s2 & ~s.cc_s3;

    // -- access check --
    end_addr = {1'b0, acc_addr_i} + {26'h000_0000, acc_len_m1_i};
    range_ok = in_range(acc_addr_i, s.lim_lo, s.lim_hi);
    if (seg_addr_inc_i) begin
      // wrap past the top of the space counts as out of range
      range_ok = range_ok && !end_addr[32] &&
                 in_range(end_addr[31:0], s.lim_lo, s.lim_hi);
    end

    case (acc_target_i)
      IOL_TGT_BUS_IO: begin
        if (seg_priv_key_i && !acc_time_delay_i && !range_ok) begin
          acc_code = IOL_ERR_LIMIT;
        end
      end
      IOL_TGT_BUS_MEM: begin
        // handled as the channel 15 bus master
        if (!seg_bypass_i) begin
          if (!tcw_present_i) begin
            acc_code = IOL_ERR_INV_OP;
          end else if (tcw_map_i == IOL_MAP_PAGE_FLT) begin
            acc_code = IOL_ERR_PAGE;
          end else if (seg_priv_key_i && !mask[tcw_key_i]) begin
            acc_code = IOL_ERR_AUTH;
          end else if (tcw_map_i[1] && acc_write_i &&
                       tcw_read_only_i) begin
            acc_code = IOL_ERR_AUTH;
          end
        end
      end
      IOL_TGT_FACILITY: begin
        if (seg_priv_key_i) begin
          acc_code = IOL_ERR_INV_OP;
        end
      end
      default: begin
        acc_code = IOL_ERR_INV_OP;
      end
    endcase

    if (acc_valid_i) begin
      n.chk_done = 1'b1;
      n.chk_pass = (acc_code == IOL_ERR_NONE);
    end

    // -- transfer response, highest precedence first --
    if (xfer_addr_chk_i && !card_select_feedback_i) begin
      xfer_code = IOL_ERR_CSF;
    end else if (rsp_chan_chk_i) begin
      xfer_code = IOL_ERR_CHAN_CHK;
    end else if ((rsp_parity_i && xfer_load_i) || rsp_tcw_par_i) begin
      xfer_code = IOL_ERR_PARITY;
    end else if (rsp_bus_err_i) begin
      xfer_code = IOL_ERR_BUS;
    end else if (rsp_ecc_i) begin
      xfer_code = IOL_ERR_ECC;
    end else if (rsp_no_ack_i) begin
      xfer_code = IOL_ERR_SYS_ADDR;
    end else if (rsp_reload_err_i && !xfer_bypass_i) begin
      xfer_code = IOL_ERR_RELOAD;
    end else if (rsp_internal_i) begin
      xfer_code = IOL_ERR_INTERNAL;
    end

    // -- register port --
    prot_reg = (reg_addr_i == IOL_OFS_LIM_LO) ||
               (reg_addr_i == IOL_OFS_LIM_HI) ||
               (reg_addr_i == IOL_OFS_CHANNEL15_STATUS_REG);
    priv_bad = (reg_wr_i || reg_rd_i) && prot_reg && reg_priv_key_i;
    if (priv_bad) begin
      reg_code = IOL_ERR_INV_OP;
    end

    if (reg_wr_i && !priv_bad) begin
      case (reg_addr_i)
        IOL_OFS_LIM_LO: n.lim_lo = reg_wdata_i;
        IOL_OFS_LIM_HI: n.lim_hi = reg_wdata_i;
        IOL_OFS_CHANNEL15_STATUS_REG:  n.csr    = reg_wdata_i;
        default: begin
        end
      endcase
    end

    if (reg_rd_i && !priv_bad) begin
      case (reg_addr_i)
        IOL_OFS_LIM_LO: n.rd_data = s.lim_lo;
        IOL_OFS_LIM_HI: n.rd_data = s.lim_hi;
        IOL_OFS_CHANNEL15_STATUS_REG:  n.rd_data = s.csr;
        default:        n.rd_data = IOL_ZERO32;
      endcase
    end

    // the finishing transfer is the older instruction, so it wins
    if (xfer_done_i && xfer_code != IOL_ERR_NONE) begin
      new_code = xfer_code;
    end else if (acc_valid_i && acc_code != IOL_ERR_NONE) begin
      new_code = acc_code;
    end else begin
      new_code = reg_code;
    end

    // interrupt is posted even when an earlier code is kept
    n.dsi = (new_code != IOL_ERR_NONE);
    // latch against the held code; set wins over a same-cycle store
    if (new_code != IOL_ERR_NONE &&
        s.csr[IOL_CODE_LSB +: 4] == IOL_ERR_NONE) begin
      n.csr[IOL_CODE_LSB +: 4] = new_code;
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      s.lim_lo   <= IOL_LIM_LO_RST;
      s.lim_hi   <= IOL_LIM_HI_RST;
      s.csr      <= IOL_CSR_RST;
      s.rd_data  <= IOL_ZERO32;
      s.chk_done <= 1'b0;
      s.chk_pass <= 1'b0;
      s.dsi      <= 1'b0;
      s.misc_int <= 1'b0;
      s.chan_en  <= 1'b1;
      s.cc_s1    <= 1'b0;
      s.cc_s2    <= 1'b0;
      s.cc_s3    <= 1'b0;
    end else begin
      s <= n;
    end
  end

  assign reg_rdata_o = s.rd_data;
  assign chk_done_o  = s.chk_done;
  assign chk_pass_o  = s.chk_pass;
  assign dsi_o       = s.dsi;
  assign misc_int_o  = s.misc_int;
  assign chan15_en_o = s.chan_en;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!reset_n_i);

  logic [3:0] code_q;
  assign code_q = s.csr[IOL_CODE_LSB +: 4];

  first_code_a: assert property (
    (code_q != IOL_ERR_NONE) && !reg_wr_i |=> $stable(code_q))
    else $error("held error code changed");

  limit_err_a: assert property (
    acc_valid_i && acc_target_i == IOL_TGT_BUS_IO && seg_priv_key_i &&
    !acc_time_delay_i && acc_addr_i < s.lim_lo && !xfer_done_i
    |=> dsi_o && !chk_pass_o)
    else $error("out of range I/O not flagged");

  range_skip_a: assert property (
    acc_valid_i && acc_target_i == IOL_TGT_BUS_IO &&
    (!seg_priv_key_i || acc_time_delay_i) |=> chk_done_o && chk_pass_o)
    else $error("range check not skipped");

  key_check_a: assert property (
    acc_valid_i && acc_target_i == IOL_TGT_BUS_MEM && seg_priv_key_i &&
    !seg_bypass_i && tcw_present_i && tcw_map_i == 2'h0 &&
    !s.csr[IOL_MASK_LSB + tcw_key_i] |=> !chk_pass_o && dsi_o)
    else $error("unauthorized key passed");

  bypass_skip_a: assert property (
    acc_valid_i && acc_target_i == IOL_TGT_BUS_MEM && seg_bypass_i
    |=> chk_pass_o)
    else $error("bypass did not skip key check");

  priv_reg_a: assert property (
    reg_wr_i && reg_priv_key_i && reg_addr_i == IOL_OFS_LIM_LO
    |=> $stable(s.lim_lo) && dsi_o)
    else $error("user write to limit register taken");

  chan_en_a: assert property (
    ##1 chan15_en_o)
    else $error("channel 15 disabled");

  csf_first_a: assert property (
    xfer_done_i && xfer_addr_chk_i && !card_select_feedback_i &&
    rsp_chan_chk_i && code_q == IOL_ERR_NONE
    |=> code_q == IOL_ERR_CSF)
    else $error("card select error not given precedence");

  async_chk_a: assert property (
    $rose(chan_chk_async_i) |-> ##[2:4] misc_int_o)
    else $error("async channel check not routed");

  csr_read_a: assert property (
    reg_rd_i && !reg_priv_key_i && reg_addr_i == IOL_OFS_CHANNEL15_STATUS_REG
    |=> reg_rdata_o == $past(s.csr))
    else $error("status read mismatch");

  cov_limit_c: cover property (
    acc_valid_i && acc_target_i == IOL_TGT_BUS_IO ##1 dsi_o);
  cov_page_c: cover property (
    acc_valid_i && tcw_map_i == IOL_MAP_PAGE_FLT ##1 code_q == IOL_ERR_PAGE);
  cov_keep_c: cover property (
    code_q != IOL_ERR_NONE && xfer_done_i && rsp_ecc_i ##1 dsi_o);
  cov_clear_c: cover property (
    code_q != IOL_ERR_NONE ##1 code_q == IOL_ERR_NONE);

endmodule

// [test/iol_proc_model.sv]
/*
  Processor model: issues register loads/stores and access checks.
  Assumes one clock; signals change just after a rising edge.
*/
`timescale 1ns/1ps
module iol_proc_model
  import iol_pkg::*;
(
  // clock and read data
  input  wire logic        sys_clk_i,
  input  wire logic [31:0] rdata_i,
  // register port
  output logic      [3:0]  addr_o,
  output logic      [31:0] wdata_o,
  output logic             wr_o,
  output logic             rd_o,
  output logic             priv_o,
  // access request
  output logic             acc_valid_o,
  output logic      [1:0]  target_o,
  output logic      [31:0] acc_addr_o,
  output logic      [6:0]  len_m1_o,
  output logic             write_o,
  output logic             time_delay_o,
  output logic             seg_priv_o,
  output logic             seg_bypass_o,
  output logic             seg_inc_o,
  output logic             tcw_present_o,
  output logic      [2:0]  tcw_key_o,
  output logic      [1:0]  tcw_map_o,
  output logic             tcw_ro_o
);
  logic [36:0] reg_f = '0;
  logic [52:0] acc_f = '0;

  initial wr_o = 1'b0;
  initial rd_o = 1'b0;
  initial acc_valid_o = 1'b0;
  assign {addr_o, wdata_o, priv_o} = reg_f;
  assign {target_o, acc_addr_o, len_m1_o, write_o, time_delay_o,
          seg_priv_o, seg_bypass_o, seg_inc_o, tcw_present_o,
          tcw_key_o, tcw_map_o, tcw_ro_o} = acc_f;

  // released fields flip so a stale value never looks valid
  task automatic reg_write(input logic [3:0] a, input logic [31:0] dt,
                           input logic k);
    @(posedge sys_clk_i);
    reg_f <= {a, dt, k};
    wr_o  <= 1'b1;
    @(posedge sys_clk_i);
    wr_o  <= 1'b0;
    reg_f <= ~reg_f;
  endtask

  task automatic reg_read(input logic [3:0] a, input logic k,
                          output logic [31:0] dt);
    @(posedge sys_clk_i);
    reg_f <= {a, 32'h0000_0000, k};
    rd_o  <= 1'b1;
    @(posedge sys_clk_i);
    rd_o  <= 1'b0;
    reg_f <= ~reg_f;
    #1;
    dt = rdata_i;
  endtask

  // returns just after the answer lands
  task automatic access(input logic [1:0] tg, input logic [31:0] a,
    input logic [6:0] l, input logic w, td, sp, by, inc, pr,
    input logic [2:0] k, input logic [1:0] m, input logic ro);
    @(posedge sys_clk_i);
    acc_f       <= {tg, a, l, w, td, sp, by, inc, pr, k, m, ro};
    acc_valid_o <= 1'b1;
    @(posedge sys_clk_i);
    acc_valid_o <= 1'b0;
    acc_f       <= ~acc_f;
    #1;
  endtask
endmodule

// [test/iol_access_check_tb.sv]
/*
  Bench for the access checker: processor model drives requests,
  the bench stands in for the I/O bus and judges every answer.
  Assumes the assertions live in the design files.
*/
`timescale 1ns/1ps
`define CHK(nm, exp, got) \
  begin \
    total_checks++; \
    if ((got) !== (exp)) begin \
      num_errors++; \
      $display("CHECK FAILED %s exp %0h got %0h", nm, exp, got); \
    end \
  end
module iol_access_check_tb
  import iol_pkg::*;
;
  localparam logic Y = 1'b1;
  localparam logic N = 1'b0;
  logic        sys_clk_i = 1'b0;
  logic        reset_n_i = 1'b0;
  logic [3:0]  reg_addr_i;
  logic [31:0] reg_wdata_i, reg_rdata_o, acc_addr_i, rd_v;
  logic        reg_wr_i, reg_rd_i, reg_priv_key_i, acc_valid_i;
  logic [1:0]  acc_target_i, tcw_map_i;
  logic [6:0]  acc_len_m1_i;
  logic [2:0]  tcw_key_i;
  logic        acc_write_i, acc_time_delay_i, seg_priv_key_i;
  logic        seg_bypass_i, seg_addr_inc_i, tcw_present_i, tcw_read_only_i;
  logic        xfer_done_i = 1'b0;
  logic        chan_chk_async_i = 1'b0;
  logic        xfer_load_i, xfer_addr_chk_i, xfer_bypass_i;
  logic        card_select_feedback_i, rsp_chan_chk_i, rsp_parity_i;
  logic        rsp_tcw_par_i, rsp_bus_err_i, rsp_ecc_i, rsp_no_ack_i;
  logic        rsp_reload_err_i, rsp_internal_i;
  logic        chk_done_o, chk_pass_o, dsi_o, misc_int_o, chan15_en_o;
  logic [11:0] rsp_r = 12'h000;
  logic [7:0]  cur_mask = 8'h00;
  int          num_errors = 0, total_checks = 0, dsi_cnt = 0, misc_cnt = 0;

  assign {xfer_load_i, xfer_addr_chk_i, xfer_bypass_i,
          card_select_feedback_i, rsp_chan_chk_i, rsp_parity_i,
          rsp_tcw_par_i, rsp_bus_err_i, rsp_ecc_i, rsp_no_ack_i,
          rsp_reload_err_i, rsp_internal_i} = rsp_r;

  iol_access_check iol_access_check_i (.*);
  iol_proc_model iol_proc_model_i (
    .sys_clk_i(sys_clk_i), .rdata_i(reg_rdata_o), .addr_o(reg_addr_i),
    .wdata_o(reg_wdata_i), .wr_o(reg_wr_i), .rd_o(reg_rd_i),
    .priv_o(reg_priv_key_i), .acc_valid_o(acc_valid_i),
    .target_o(acc_target_i), .acc_addr_o(acc_addr_i),
    .len_m1_o(acc_len_m1_i), .write_o(acc_write_i),
    .time_delay_o(acc_time_delay_i), .seg_priv_o(seg_priv_key_i),
    .seg_bypass_o(seg_bypass_i), .seg_inc_o(seg_addr_inc_i),
    .tcw_present_o(tcw_present_i), .tcw_key_o(tcw_key_i),
    .tcw_map_o(tcw_map_i), .tcw_ro_o(tcw_read_only_i));

  always #5 sys_clk_i = ~sys_clk_i;
  always @(posedge sys_clk_i) begin
    if (dsi_o === 1'b1) dsi_cnt++;
    if (misc_int_o === 1'b1) misc_cnt++;
  end

  // ----------------------------------------------------------------
  // shared helpers
  // ----------------------------------------------------------------
  task automatic code_is(input logic [3:0] exp);
    iol_proc_model_i.reg_read(IOL_OFS_CHANNEL15_STATUS_REG, N, rd_v);
    `CHK("status code", exp, rd_v[31:28])
  endtask
  task automatic clear(input logic [7:0] mask);
    cur_mask = mask;
    iol_proc_model_i.reg_write(IOL_OFS_CHANNEL15_STATUS_REG, {8'h00, mask, 16'h0000}, N);
  endtask
  task automatic acc_chk(input logic [1:0] tg, input logic [31:0] a,
    input logic [6:0] l, input logic w, td, sp, by, inc, pr,
    input logic [2:0] k, input logic [1:0] m, input logic ro, ps,
    input logic [3:0] c);
    iol_proc_model_i.access(tg, a, l, w, td, sp, by, inc, pr, k, m, ro);
    `CHK("chk done", Y, chk_done_o)
    `CHK("chk pass", ps, chk_pass_o)
    `CHK("access dsi", ~ps, dsi_o)
    code_is(c);
    clear(cur_mask);
  endtask
  task automatic io_chk(input logic [31:0] a, input logic [6:0] l,
    input logic inc, sp, td, ps, input logic [3:0] c);
    acc_chk(IOL_TGT_BUS_IO, a, l, N, td, sp, N, inc, N, 3'h0, 2'h0, N,
            ps, c);
  endtask
  task automatic mem_chk(input logic [1:0] tg, input logic w, sp, by, pr,
    input logic [2:0] k, input logic [1:0] m, input logic ro, ps,
    input logic [3:0] c);
    acc_chk(tg, 32'h0001_0000, 7'h03, w, N, sp, by, Y, pr, k, m, ro, ps, c);
  endtask
  // response lines flip after the done pulse: only valid with it
  task automatic xfer(input logic [11:0] v, input logic exp_dsi);
    @(posedge sys_clk_i);
    rsp_r       <= v;
    xfer_done_i <= Y;
    @(posedge sys_clk_i);
    rsp_r       <= ~v;
    xfer_done_i <= N;
    #1;
    `CHK("xfer dsi", exp_dsi, dsi_o)
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    `CHK("chan15 enable", Y, chan15_en_o)
    `CHK("idle done", N, chk_done_o)
    `CHK("idle misc", N, misc_int_o)
    code_is(IOL_ERR_NONE);
    iol_proc_model_i.reg_read(IOL_OFS_LIM_HI, N, rd_v);
    `CHK("high limit reset", IOL_LIM_HI_RST, rd_v)
    iol_proc_model_i.reg_read(4'hC, N, rd_v);
    `CHK("unmapped read", IOL_ZERO32, rd_v)
    `CHK("unmapped dsi", 0, dsi_cnt)
  endtask
  task automatic t_regs();
    iol_proc_model_i.reg_write(IOL_OFS_CHANNEL15_STATUS_REG, 32'h0ABC_DEF0, N);
    iol_proc_model_i.reg_read(IOL_OFS_CHANNEL15_STATUS_REG, N, rd_v);
    `CHK("status stored", 32'h0ABC_DEF0, rd_v)
    iol_proc_model_i.reg_write(IOL_OFS_LIM_LO, 32'h0000_0100, N);
    iol_proc_model_i.reg_write(IOL_OFS_LIM_LO, 32'h0000_0055, Y);
    iol_proc_model_i.reg_read(IOL_OFS_LIM_LO, Y, rd_v);
    `CHK("user read", IOL_ZERO32, rd_v)
    `CHK("user read dsi", Y, dsi_o)
    `CHK("user write dsi", 1, dsi_cnt)
    iol_proc_model_i.reg_read(IOL_OFS_LIM_LO, N, rd_v);
    `CHK("low limit kept", 32'h0000_0100, rd_v)
    code_is(IOL_ERR_INV_OP);
    xfer(12'h108, Y);
    code_is(IOL_ERR_INV_OP);
    clear(8'h00);
    code_is(IOL_ERR_NONE);
    xfer(12'h108, Y);
    code_is(IOL_ERR_ECC);
    clear(8'h00);
  endtask
  task automatic t_range();
    iol_proc_model_i.reg_write(IOL_OFS_LIM_HI, 32'h0000_01FF, N);
    io_chk(32'h0000_0100, 7'h00, N, Y, N, Y, 4'h0);
    io_chk(32'h0000_00FF, 7'h00, N, Y, N, N, 4'h3);
    io_chk(32'h0000_0200, 7'h00, N, Y, N, N, 4'h3);
    io_chk(32'h0000_01FF, 7'h03, N, Y, N, Y, 4'h0);
    io_chk(32'h0000_01FF, 7'h03, Y, Y, N, N, 4'h3);
    io_chk(32'h0000_01FC, 7'h03, Y, Y, N, Y, 4'h0);
    io_chk(32'h0000_0300, 7'h00, N, N, N, Y, 4'h0);
    io_chk(32'h0000_0300, 7'h00, N, Y, Y, Y, 4'h0);
  endtask
  task automatic t_mem();
    clear(8'h04);
    mem_chk(IOL_TGT_BUS_MEM, N, Y, N, Y, 3'h2, 2'h0, N, Y, 4'h0);
    mem_chk(IOL_TGT_BUS_MEM, N, Y, N, Y, 3'h3, 2'h0, N, N, 4'h5);
    mem_chk(IOL_TGT_BUS_MEM, N, N, N, Y, 3'h3, 2'h0, N, Y, 4'h0);
    mem_chk(IOL_TGT_BUS_MEM, N, Y, Y, Y, 3'h3, 2'h0, N, Y, 4'h0);
    mem_chk(IOL_TGT_BUS_MEM, N, Y, N, N, 3'h2, 2'h0, N, N, 4'h1);
    mem_chk(IOL_TGT_BUS_MEM, N, Y, Y, N, 3'h2, 2'h0, N, Y, 4'h0);
    mem_chk(IOL_TGT_BUS_MEM, N, Y, N, Y, 3'h2, 2'h1, N, N, 4'h6);
    mem_chk(IOL_TGT_BUS_MEM, Y, Y, N, Y, 3'h2, 2'h2, Y, N, 4'h5);
    mem_chk(IOL_TGT_BUS_MEM, Y, Y, N, Y, 3'h2, 2'h2, N, Y, 4'h0);
    mem_chk(IOL_TGT_BUS_MEM, N, Y, N, Y, 3'h2, 2'h2, Y, Y, 4'h0);
    mem_chk(IOL_TGT_FACILITY, N, Y, N, Y, 3'h2, 2'h0, N, N, 4'h1);
    mem_chk(IOL_TGT_FACILITY, N, N, N, Y, 3'h2, 2'h0, N, Y, 4'h0);
    mem_chk(IOL_TGT_UNAUTH, N, Y, N, Y, 3'h2, 2'h0, N, N, 4'h1);
  endtask
  task automatic t_keys();
    for (int k = 0; k < 8; k++) begin
      clear(8'h01 << k);
      mem_chk(IOL_TGT_BUS_MEM, N, Y, N, Y, k[2:0], 2'h0, N, Y, 4'h0);
      mem_chk(IOL_TGT_BUS_MEM, N, Y, N, Y, ~k[2:0], 2'h0, N, N, 4'h5);
    end
  endtask
  // entry: load,addr chk,bypass,feedback,responses[7:0], then code
  task automatic t_xfer();
    // parity on a store and reload with bypass on must both stay quiet
    logic [15:0] tbl [15] = '{16'h480B, 16'h0000, 16'h9C08, 16'h9409,
      16'h1209, 16'h110A, 16'h118A, 16'h108C, 16'h104D, 16'h102E,
      16'h101F, 16'h5000, 16'h105D, 16'h1400, 16'h3020};
    clear(8'h00);
    foreach (tbl[i]) begin
      xfer(tbl[i][15:4], tbl[i][3:0] != 4'h0);
      code_is(tbl[i][3:0]);
      clear(8'h00);
    end
    `CHK("chan15 after errors", Y, chan15_en_o)
  endtask
  task automatic t_async();
    int m0;
    int d0;
    m0 = misc_cnt;
    d0 = dsi_cnt;
    @(posedge sys_clk_i);
    chan_chk_async_i <= Y;
    repeat (2) @(posedge sys_clk_i);
    #1;
    `CHK("misc early", m0, misc_cnt)
    repeat (8) @(posedge sys_clk_i);
    chan_chk_async_i <= N;
    repeat (8) @(posedge sys_clk_i);
    #1;
    `CHK("misc pulses", m0 + 1, misc_cnt)
    `CHK("async dsi", d0, dsi_cnt)
    code_is(IOL_ERR_NONE);
  endtask

  // ----------------------------------------------------------------
  // run control
  // ----------------------------------------------------------------
  task automatic finish_test();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge sys_clk_i);
    reset_n_i <= Y;
    t_reset();
    t_regs();
    t_range();
    t_mem();
    t_keys();
    t_xfer();
    t_async();
    finish_test();
  end
  // the whole run needs a few hundred cycles
  initial begin
    #200000;
    num_errors++;
    finish_test();
  end
endmodule
